//--- core/blt_map.vh
// register map, field positions, limits and sizes of the buffer level trigger
// Function
// R1: computed source current threshold within +/-1.0E7
// R2: raw source, relative off: current 0..6.1
// R3: current threshold powers up as 0
// R4: current trigger evaluated only when enabled
// R5: readable flag shows a trigger has fired
// R6: keep 0..100 pre-trigger readings, default 0
// R7: voltage fires on rising or falling crossing
// R8: computed source voltage threshold within +/-1.0E8
// R9: raw source, relative off: voltage 0..20
// R10: voltage threshold powers up as 0
// R11: voltage trigger evaluated only when enabled
// R12: current fires on rising or falling crossing
// R13: compare each reading; flag holds until rearm
// R14: circular history keeps pre-trigger readings
`ifndef BLT_MAP_VH
`define BLT_MAP_VH
// ----------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------
`define BLT_W 40
`define BLT_AW 7
`define BLT_DEPTH 128
`define BLT_PRE_MAX 7'h64
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define BLT_CTRL 8'h00
`define BLT_CMD 8'h04
`define BLT_STAT 8'h08
`define BLT_PRE 8'h0c
`define BLT_VTH_LO 8'h10
`define BLT_VTH_HI 8'h14
`define BLT_ITH_LO 8'h18
`define BLT_ITH_HI 8'h1c
`define BLT_LOGCNT 8'h20
// ----------------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------------
`define BLT_C_VEN 0
`define BLT_C_IEN 1
`define BLT_C_VFALL 2
`define BLT_C_IFALL 3
`define BLT_C_COMP 4
`define BLT_C_REL 5
`define BLT_CMD_REARM 0
`define BLT_S_SEEN 0
`define BLT_S_LOG 1
`define BLT_S_VHIT 2
`define BLT_S_IHIT 3
// ----------------------------------------------------------------------
// threshold limits, milli-volt and milli-ampere
// ----------------------------------------------------------------------
`define BLT_V_COMP_LIM 40'h174876e800
`define BLT_I_COMP_LIM 40'h02540be400
`define BLT_V_RAW_LIM 40'h0000004e20
`define BLT_I_RAW_LIM 40'h00000017d4
`endif

//--- core/blt_level_cmp.v
// threshold crossing detector for one reading channel
`timescale 1ns/1ps
`include "blt_map.vh"
module blt_level_cmp
(
  input wire enable,
  input wire fall,
  input wire prevOk,
  input wire [`BLT_W-1:0] threshold,
  input wire [`BLT_W-1:0] prev,
  input wire [`BLT_W-1:0] cur,
  output wire hit
);
  wire signed [`BLT_W-1:0] th = threshold;
  wire signed [`BLT_W-1:0] p = prev;
  wire signed [`BLT_W-1:0] c = cur;
  wire up = (p < th) && (c >= th);
  wire down = (p > th) && (c <= th);
  // ignored entirely while disabled
  assign hit = enable && prevOk && (fall ? down : up); // R4 R11 R7 R12
endmodule // blt_level_cmp

//--- core/blt_history.v
// circular history of voltage and current reading pairs
`timescale 1ns/1ps
`include "blt_map.vh"
module blt_history
(
  input wire clock,
  input wire wrEn,
  input wire [`BLT_AW-1:0] wrIdx,
  input wire [2*`BLT_W-1:0] wrData,
  input wire [`BLT_AW-1:0] rdIdx,
  output wire [2*`BLT_W-1:0] rdData
);
  reg [2*`BLT_W-1:0] mem [0:`BLT_DEPTH-1];
  // oldest entry overwritten once full
  always @(posedge clock)
  begin
    if (wrEn)
    begin
      mem[wrIdx] <= wrData; // R14
    end
  end
  assign rdData = mem[rdIdx];
endmodule // blt_history

//--- core/blt_top.v
// buffer level trigger with apb registers and pre-trigger history
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "blt_map.vh"
module blt_top
(
  input wire clock,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire rdValid,
  input wire [`BLT_W-1:0] rdVolt,
  input wire [`BLT_W-1:0] rdCurr,
  output wire logValid,
  output wire [`BLT_W-1:0] logVolt,
  output wire [`BLT_W-1:0] logCurr,
  output wire trigSeen,
  output wire trigPulse
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg [5:0] ctrl_q;
  reg [6:0] preCnt_q;
  reg [`BLT_W-1:0] vTh_q;
  reg [`BLT_W-1:0] iTh_q;
  reg [31:0] loPend_q;
  reg [31:0] prdata_q;
  reg pready_q;
  reg pslverr_q;
  reg seen_q;
  reg logging_q;
  reg vHit_q;
  reg iHit_q;
  reg prevOk_q;
  reg [`BLT_W-1:0] prevV_q;
  reg [`BLT_W-1:0] prevI_q;
  reg [6:0] fillCnt_q;
  reg [`BLT_AW-1:0] wrPtr_q;
  reg [`BLT_AW-1:0] rdPtr_q;
  reg [31:0] logCnt_q;
  reg logValid_q;
  reg [`BLT_W-1:0] logVolt_q;
  reg [`BLT_W-1:0] logCurr_q;
  reg trigPulse_q;
  // ----------------------------------------------------------------------
  // threshold limiting
  // ----------------------------------------------------------------------
  function [`BLT_W-1:0] limitTh;
    input [`BLT_W-1:0] v;
    input [`BLT_W-1:0] compLim;
    input [`BLT_W-1:0] rawLim;
    input comp;
    input rel;
    reg signed [`BLT_W-1:0] sv;
    reg signed [`BLT_W-1:0] hi;
    reg signed [`BLT_W-1:0] lo;
    begin
      sv = v;
      if (!comp && !rel)
      begin
        hi = rawLim;
        lo = {`BLT_W{1'b0}};
      end
      else
      begin
        hi = compLim;
        lo = -$signed(compLim);
      end
      if (sv > hi)
        limitTh = hi;
      else if (sv < lo)
        limitTh = lo;
      else
        limitTh = sv;
    end
  endfunction
  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  wire setup = psel && !penable;
  wire access = psel && penable && pready_q;
  wire wrAcc = access && pwrite;
  wire [`BLT_W-1:0] thNew = {pwdata[7:0], loPend_q};
  wire rearm = wrAcc && (paddr == `BLT_CMD) && pwdata[`BLT_CMD_REARM];
  reg [31:0] rdVal;
  reg mapped;
  always @*
  begin
    rdVal = 32'h0;
    mapped = 1'b1;
    case (paddr)
      `BLT_CTRL: rdVal = {26'h0, ctrl_q};
      `BLT_CMD: rdVal = 32'h0;
      `BLT_STAT: rdVal = {9'h0, fillCnt_q, 12'h0, iHit_q, vHit_q, logging_q, seen_q}; // R5
      `BLT_PRE: rdVal = {25'h0, preCnt_q};
      `BLT_VTH_LO: rdVal = vTh_q[31:0];
      `BLT_VTH_HI: rdVal = {24'h0, vTh_q[39:32]};
      `BLT_ITH_LO: rdVal = iTh_q[31:0];
      `BLT_ITH_HI: rdVal = {24'h0, iTh_q[39:32]};
      `BLT_LOGCNT: rdVal = logCnt_q;
      default: mapped = 1'b0;
    endcase
  end
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      pready_q <= setup;
      if (setup)
      begin
        prdata_q <= pwrite ? 32'h0 : rdVal;
        pslverr_q <= !mapped;
      end
    end
  end
  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      ctrl_q <= 6'h0; // R4 R11 R7 R12
      preCnt_q <= 7'h0; // R6
      vTh_q <= {`BLT_W{1'b0}}; // R10
      iTh_q <= {`BLT_W{1'b0}}; // R3
      loPend_q <= 32'h0;
    end
    else if (wrAcc)
    begin
      case (paddr)
        `BLT_CTRL: ctrl_q <= pwdata[5:0];
        `BLT_PRE:
        begin
          if (pwdata > {25'h0, `BLT_PRE_MAX})
            preCnt_q <= `BLT_PRE_MAX; // R6
          else
            preCnt_q <= pwdata[6:0];
        end
        `BLT_VTH_LO: loPend_q <= pwdata;
        `BLT_ITH_LO: loPend_q <= pwdata;
        `BLT_VTH_HI:
          vTh_q <= limitTh(thNew, `BLT_V_COMP_LIM, `BLT_V_RAW_LIM,
            ctrl_q[`BLT_C_COMP], ctrl_q[`BLT_C_REL]); // R8 R9
        `BLT_ITH_HI:
          iTh_q <= limitTh(thNew, `BLT_I_COMP_LIM, `BLT_I_RAW_LIM,
            ctrl_q[`BLT_C_COMP], ctrl_q[`BLT_C_REL]); // R1 R2
        default: loPend_q <= loPend_q;
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // level comparison
  // ----------------------------------------------------------------------
  wire vHit;
  wire iHit;
  blt_level_cmp uCmpV
  (
    .enable(ctrl_q[`BLT_C_VEN]),
    .fall(ctrl_q[`BLT_C_VFALL]),
    .prevOk(prevOk_q),
    .threshold(vTh_q),
    .prev(prevV_q),
    .cur(rdVolt),
    .hit(vHit)
  );
  blt_level_cmp uCmpI
  (
    .enable(ctrl_q[`BLT_C_IEN]),
    .fall(ctrl_q[`BLT_C_IFALL]),
    .prevOk(prevOk_q),
    .threshold(iTh_q),
    .prev(prevI_q),
    .cur(rdCurr),
    .hit(iHit)
  );
  // each arriving reading checked once, only while armed
  wire fire = rdValid && !seen_q && (vHit || iHit); // R13
  wire [6:0] keep = (preCnt_q < fillCnt_q) ? preCnt_q : fillCnt_q;
  // ----------------------------------------------------------------------
  // trigger state
  // ----------------------------------------------------------------------
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      seen_q <= 1'b0;
      vHit_q <= 1'b0;
      iHit_q <= 1'b0;
      trigPulse_q <= 1'b0;
      prevOk_q <= 1'b0;
      prevV_q <= {`BLT_W{1'b0}};
      prevI_q <= {`BLT_W{1'b0}};
    end
    else
    begin
      trigPulse_q <= fire;
      if (fire)
      begin
        // a trigger in the rearm cycle is kept
        seen_q <= 1'b1; // R5 R13
        vHit_q <= vHit;
        iHit_q <= iHit;
      end
      else if (rearm)
      begin
        seen_q <= 1'b0; // R13
        vHit_q <= 1'b0;
        iHit_q <= 1'b0;
      end
      if (rearm && !fire)
        prevOk_q <= 1'b0;
      else if (rdValid)
        prevOk_q <= 1'b1;
      if (rdValid)
      begin
        prevV_q <= rdVolt;
        prevI_q <= rdCurr;
      end
    end
  end
  // ----------------------------------------------------------------------
  // history and logging
  // ----------------------------------------------------------------------
  wire [2*`BLT_W-1:0] histOut;
  wire pending = logging_q && (rdPtr_q != wrPtr_q);
  blt_history uHist
  (
    .clock(clock),
    .wrEn(rdValid),
    .wrIdx(wrPtr_q),
    .wrData({rdVolt, rdCurr}),
    .rdIdx(rdPtr_q),
    .rdData(histOut)
  );
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      wrPtr_q <= {`BLT_AW{1'b0}};
      rdPtr_q <= {`BLT_AW{1'b0}};
      fillCnt_q <= 7'h0;
      logging_q <= 1'b0;
      logCnt_q <= 32'h0;
      logValid_q <= 1'b0;
      logVolt_q <= {`BLT_W{1'b0}};
      logCurr_q <= {`BLT_W{1'b0}};
    end
    else
    begin
      if (rdValid)
        wrPtr_q <= wrPtr_q + 7'h1; // R14
      logValid_q <= pending;
      if (fire)
      begin
        // rewind to the oldest reading still wanted
        rdPtr_q <= wrPtr_q - keep; // R6 R14
        logging_q <= 1'b1;
        fillCnt_q <= 7'h0;
      end
      else
      begin
        if (rearm)
        begin
          logging_q <= 1'b0;
          fillCnt_q <= 7'h0;
          logCnt_q <= 32'h0;
        end
        else if (rdValid && !seen_q && fillCnt_q < `BLT_PRE_MAX)
          fillCnt_q <= fillCnt_q + 7'h1;
        if (pending)
          rdPtr_q <= rdPtr_q + 7'h1;
      end
      if (pending)
      begin
        logVolt_q <= histOut[2*`BLT_W-1:`BLT_W];
        logCurr_q <= histOut[`BLT_W-1:0];
        if (!rearm)
          logCnt_q <= logCnt_q + 32'h1;
      end
    end
  end
  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign logValid = logValid_q;
  assign logVolt = logVolt_q;
  assign logCurr = logCurr_q;
  assign trigSeen = seen_q;
  assign trigPulse = trigPulse_q;
endmodule // blt_top

//--- bench/blt_reading_src.sv
// reading source standing in for the measurement path
`timescale 1ns/1ps
`include "blt_map.vh"
module blt_reading_src
(
  input wire clock,
  output logic rdValid,
  output logic [`BLT_W-1:0] rdVolt,
  output logic [`BLT_W-1:0] rdCurr
);
  initial
  begin
    rdValid = 1'b0;
    rdVolt = '0;
    rdCurr = '0;
  end
  // one reading pair, held over one edge
  task send(input logic [`BLT_W-1:0] v, input logic [`BLT_W-1:0] i);
    rdValid <= 1'b1;
    rdVolt <= v;
    rdCurr <= i;
    @(posedge clock);
  endtask
  // released lines show the inverse of the last value
  task quiet();
    rdValid <= 1'b0;
    rdVolt <= ~rdVolt;
    rdCurr <= ~rdCurr;
    @(posedge clock);
  endtask
endmodule // blt_reading_src

//--- bench/blt_top_monitor.sv
// assertions on the ports of the buffer level trigger
`timescale 1ns/1ps
`include "blt_map.vh"
module blt_top_monitor
(
  input wire clock,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire rdValid,
  input wire logValid,
  input wire trigSeen,
  input wire trigPulse
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  wire rearmWr = psel && penable && pready && pwrite && paddr == `BLT_CMD && pwdata[0];
  sequence setupPhase;
    psel && !penable;
  endsequence
  sequence accessDone;
    psel && penable && pready;
  endsequence
  chk_ready_follows: assert property (setupPhase |=> accessDone)
    else $error("setup not answered next cycle");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_seen_holds: assert property (trigSeen && !rearmWr |=> trigSeen)
    else $error("seen flag dropped without rearm");
  chk_seen_clear: assert property (rearmWr && !rdValid |=> !trigSeen)
    else $error("seen flag kept after rearm");
  chk_rise_pulse: assert property ($rose(trigSeen) |-> trigPulse)
    else $error("seen flag rose without pulse");
  chk_pulse_cause: assert property (trigPulse |-> $past(rdValid) && trigSeen)
    else $error("pulse without a reading");
  chk_pulse_single: assert property (trigPulse |=> !trigPulse)
    else $error("pulse longer than one cycle");
  chk_log_follows: assert property (trigPulse |=> logValid)
    else $error("logging did not start after trigger");
endmodule // blt_top_monitor
bind blt_top blt_top_monitor blt_top_monitor_i(.clock(clock), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .rdValid(rdValid), .logValid(logValid), .trigSeen(trigSeen),
  .trigPulse(trigPulse));

//--- bench/tb_top.sv
// testbench of the buffer level trigger
`timescale 1ns/1ps
`include "blt_map.vh"
module tb_top;
  logic clock, rstn, psel, penable, pwrite, pready, pslverr, rdValid, logValid;
  logic trigSeen, trigPulse, rdErr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdData;
  logic [`BLT_W-1:0] rdVolt, rdCurr, logVolt, logCurr;
  logic [2*`BLT_W-1:0] logQ[$];
  int failCount = 0;
  int checksDone = 0;
  blt_top blt_top_i(.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rdValid(rdValid), .rdVolt(rdVolt), .rdCurr(rdCurr),
    .logValid(logValid), .logVolt(logVolt), .logCurr(logCurr), .trigSeen(trigSeen),
    .trigPulse(trigPulse));
  blt_reading_src blt_reading_src_i(.clock(clock), .rdValid(rdValid), .rdVolt(rdVolt),
    .rdCurr(rdCurr));
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock)
    if (logValid === 1'b1)
      logQ.push_back({logVolt, logCurr});
  task results();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [79:0] got, input logic [79:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      failCount++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      failCount++;
      results();
    end
    else
    begin
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rdData, e);
  endtask
  task tw(input logic [7:0] a, input logic [`BLT_W-1:0] v);
    apb(1'b1, a, v[31:0]);
    apb(1'b1, a + 8'h4, {24'h0, v[39:32]});
  endtask
  task tr(input logic [7:0] a, input logic [`BLT_W-1:0] v);
    rd(a, v[31:0]);
    rd(a + 8'h4, {24'h0, v[39:32]});
  endtask
  task pair(input logic [`BLT_W-1:0] v, input logic [`BLT_W-1:0] i);
    blt_reading_src_i.send(v, i);
  endtask
  initial
  begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rd(`BLT_CTRL, 32'h0);
    rd(`BLT_PRE, 32'h0);
    tr(`BLT_VTH_LO, 40'h0);
    tr(`BLT_ITH_LO, 40'h0);
    rd(`BLT_STAT, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", rdErr, 1'b1);
    tw(`BLT_VTH_LO, 40'h7530);
    tr(`BLT_VTH_LO, `BLT_V_RAW_LIM);
    tw(`BLT_ITH_LO, 40'h1b58);
    tr(`BLT_ITH_LO, `BLT_I_RAW_LIM);
    // relative mode lifts the raw limit
    apb(1'b1, `BLT_CTRL, 32'h20);
    tw(`BLT_ITH_LO, 40'h1b58);
    tr(`BLT_ITH_LO, 40'h1b58);
    apb(1'b1, `BLT_CTRL, 32'h10);
    tw(`BLT_ITH_LO, `BLT_I_COMP_LIM + 40'h1);
    tr(`BLT_ITH_LO, `BLT_I_COMP_LIM);
    tw(`BLT_ITH_LO, 40'hfdabf41bff);
    tr(`BLT_ITH_LO, 40'hfdabf41c00);
    tw(`BLT_VTH_LO, `BLT_V_COMP_LIM + 40'h1);
    tr(`BLT_VTH_LO, `BLT_V_COMP_LIM);
    tw(`BLT_VTH_LO, 40'hfffffffffe);
    tr(`BLT_VTH_LO, 40'hfffffffffe);
    tw(`BLT_VTH_LO, 40'h32);
    tw(`BLT_ITH_LO, 40'h32);
    apb(1'b1, `BLT_PRE, 32'hc8);
    rd(`BLT_PRE, 32'h64);
    apb(1'b1, `BLT_PRE, 32'h2);
    // each channel, each direction; the other channel sees the same crossing
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, `BLT_CMD, 32'h1);
      apb(1'b1, `BLT_CTRL, 32'h10 | (k[0] ? 32'h2 : 32'h1) | (k[1] ? 32'hc : 32'h0));
      pair(k[1] ? 40'h3c : 40'ha, k[1] ? 40'h3c : 40'ha);
      pair(k[1] ? 40'h28 : 40'h3c, k[1] ? 40'h28 : 40'h3c);
      blt_reading_src_i.quiet();
      repeat (3) @(posedge clock);
      chk("seen pin", trigSeen, 1'b1);
      apb(1'b0, `BLT_STAT, 32'h0);
      chk("fired", rdData & 32'hd, k[0] ? 32'h9 : 32'h5);
    end
    apb(1'b1, `BLT_CMD, 32'h1);
    chk("seen after rearm", trigSeen, 1'b0);
    apb(1'b1, `BLT_CTRL, 32'h11);
    logQ.delete();
    for (int j = 0; j < 4; j++)
      pair(40'(10 * j + 10 + 20 * (j / 3)), 40'(j + 1));
    blt_reading_src_i.quiet();
    repeat (6) @(posedge clock);
    chk("log size", logQ.size(), 3);
    for (int j = 0; j < 3; j++)
      chk("log entry", logQ[j], {40'(10 * j + 20 + 20 * (j / 2)), 40'(j + 2)});
    rd(`BLT_LOGCNT, 32'h3);
    results();
  end
endmodule // tb_top
